/* hdl/bpg_top.sv */
// Top of the bus port GPIO block: two multiplexed address/data ports and register bank
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module bpg_top
   import bpg_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [2:0]  mode,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic             ext_echo,
   input  wire logic        bus_use,
   input  wire logic [15:0] ext_addr,
   input  wire logic [15:0] ext_wdata,
   input  wire logic        ext_data_phase,
   input  wire logic        ext_data_drive,
   input  wire logic        ext_wide,
   input  wire logic [7:0]  hi_pin_in,
   output logic      [7:0]  hi_pin_out,
   output logic      [7:0]  hi_pin_oe_n,
   input  wire logic [7:0]  lo_pin_in,
   output logic      [7:0]  lo_pin_out,
   output logic      [7:0]  lo_pin_oe_n
);
   logic [7:0] hi_rd;
   logic [7:0] lo_rd;
   logic [7:0] hi_dir;
   logic [7:0] lo_dir;
   logic       hi_data_we;
   logic       lo_data_we;
   logic       hi_dir_we;
   logic       lo_dir_we;
   logic [7:0] hi_bus_out;
   logic [7:0] lo_bus_out;
   logic [7:0] hi_bus_drv;
   logic [7:0] lo_bus_drv;

   ////////////////////////////////////////////////////////////////////////////////
   // Narrow bus carries the low data byte alone on the high port; wide bus puts each byte on its own port
   always_comb
   begin
      if (ext_data_phase)
      begin
         hi_bus_out = ext_wide ? ext_wdata[15:8] : ext_wdata[7:0];
         lo_bus_out = ext_wdata[7:0];
         hi_bus_drv = {8{ext_data_drive}};
         lo_bus_drv = {8{ext_data_drive & ext_wide}};
      end
      else
      begin
         hi_bus_out = ext_addr[15:8];
         lo_bus_out = ext_addr[7:0];
         hi_bus_drv = 8'hff;
         lo_bus_drv = 8'hff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   bpg_regbank u_bank (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .reg_addr   (reg_addr),
      .reg_wr     (reg_wr),
      .reg_rd     (reg_rd),
      .mode       (mode),
      .hi_rd      (hi_rd),
      .lo_rd      (lo_rd),
      .hi_dir     (hi_dir),
      .lo_dir     (lo_dir),
      .hi_data_we (hi_data_we),
      .lo_data_we (lo_data_we),
      .hi_dir_we  (hi_dir_we),
      .lo_dir_we  (lo_dir_we),
      .ext_echo   (ext_echo),
      .reg_rdata  (reg_rdata)
   );

   bpg_port #(.WIDTH(8)) u_hi (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .data_we   (hi_data_we),
      .dir_we    (hi_dir_we),
      .wdata     (reg_wdata),
      .bus_use   (bus_use),
      .bus_out   (hi_bus_out),
      .bus_drive (hi_bus_drv),
      .pin_in    (hi_pin_in),
      .pin_out   (hi_pin_out),
      .pin_oe_n  (hi_pin_oe_n),
      .data_rd   (hi_rd),
      .dir_q     (hi_dir)
   );

   bpg_port #(.WIDTH(8)) u_lo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .data_we   (lo_data_we),
      .dir_we    (lo_dir_we),
      .wdata     (reg_wdata),
      .bus_use   (bus_use),
      .bus_out   (lo_bus_out),
      .bus_drive (lo_bus_drv),
      .pin_in    (lo_pin_in),
      .pin_out   (lo_pin_out),
      .pin_oe_n  (lo_pin_oe_n),
      .data_rd   (lo_rd),
      .dir_q     (lo_dir)
   );

   ////////////////////////////////////////////////////////////////////////////////
   logic mapped_now;
   assign mapped_now = (mode == BPG_MODE_SS_SINGLE) || (mode == BPG_MODE_NS_SINGLE);

   property p_dir_reset;
      @(posedge sys_clk) $fell(sys_rst) |-> (hi_dir == 8'h00) && (lo_dir == 8'h00);
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("direction not zero after reset");

   property p_gpio_oe;
      @(posedge sys_clk) disable iff (sys_rst) !bus_use |-> (hi_pin_oe_n == ~hi_dir);
   endproperty
   a_gpio_oe: assert property (p_gpio_oe) else $error("high port enable not direction");

   property p_read_mix;
      @(posedge sys_clk) disable iff (sys_rst)
         reg_rd && mapped_now && reg_addr == BPG_OFS_LO_DATA && !lo_dir_we
         |=> reg_rdata == $past(lo_rd);
   endproperty
   a_read_mix: assert property (p_read_mix) else $error("low data read wrong");

   property p_dir_write;
      @(posedge sys_clk) disable iff (sys_rst)
         reg_wr && mapped_now && reg_addr == BPG_OFS_HI_DIR ##1 reg_rd && mapped_now
         && reg_addr == BPG_OFS_HI_DIR && !reg_wr |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost");

   property p_unmapped;
      @(posedge sys_clk) disable iff (sys_rst)
         (reg_rd || reg_wr) && !mapped_now && reg_addr <= BPG_OFS_LO_DIR |-> ext_echo;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("port access not echoed");

   property p_rsv_zero;
      @(posedge sys_clk) disable iff (sys_rst)
         reg_rd && reg_addr >= BPG_OFS_RSV_LO |=> reg_rdata == 8'h00;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");

   property p_rsv_periph;
      @(posedge sys_clk) disable iff (sys_rst)
         reg_rd && mode == BPG_MODE_PERIPHERAL |-> ext_echo;
   endproperty
   a_rsv_periph: assert property (p_rsv_periph) else $error("peripheral access not echoed");

   property p_bus_addr;
      @(posedge sys_clk) disable iff (sys_rst)
         bus_use && !ext_data_phase |-> hi_pin_out == ext_addr[15:8] && lo_pin_oe_n == 8'h00;
   endproperty
   a_bus_addr: assert property (p_bus_addr) else $error("address not on pins");

   c_gpio_out: cover property (@(posedge sys_clk) !bus_use && hi_pin_oe_n == 8'h00);
   c_read_pin: cover property (@(posedge sys_clk) reg_rd && reg_addr == BPG_OFS_HI_DATA);
   c_echo:     cover property (@(posedge sys_clk) ext_echo);
endmodule

/* hdl/bpg_pkg.sv */
// Package with register map, reset values and mode encodings for the bus port GPIO block
package bpg_pkg;
   localparam int          BPG_ADDR_W      = 4;
   localparam int          BPG_DATA_W      = 8;
   localparam logic [3:0]  BPG_OFS_HI_DATA = 4'h0;
   localparam logic [3:0]  BPG_OFS_LO_DATA = 4'h1;
   localparam logic [3:0]  BPG_OFS_HI_DIR  = 4'h2;
   localparam logic [3:0]  BPG_OFS_LO_DIR  = 4'h3;
   localparam logic [3:0]  BPG_OFS_RSV_LO  = 4'h4;
   localparam logic [3:0]  BPG_OFS_RSV_HI  = 4'h7;
   localparam logic [3:0]  BPG_OFS_RSV_F   = 4'hf;
   localparam logic [7:0]  BPG_DIR_RST     = 8'h00;
   localparam logic [7:0]  BPG_DATA_RST    = 8'h00;

   typedef enum logic [2:0] {
      BPG_MODE_SS_SINGLE  = 3'b000,
      BPG_MODE_SS_TEST    = 3'b001,
      BPG_MODE_PERIPHERAL = 3'b010,
      BPG_MODE_EM_NARROW  = 3'b011,
      BPG_MODE_NS_SINGLE  = 3'b100,
      BPG_MODE_N_NARROW   = 3'b101,
      BPG_MODE_N_WIDE     = 3'b110,
      BPG_MODE_EM_WIDE    = 3'b111
   } bpg_mode_e;
endpackage

/* hdl/bpg_port.sv */
// One 8-bit GPIO port: data and direction registers, pin muxing, read source
`timescale 1ns/1ps
module bpg_port
   import bpg_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             data_we,
   input  wire logic             dir_we,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic             bus_use,
   input  wire logic [WIDTH-1:0] bus_out,
   input  wire logic [WIDTH-1:0] bus_drive,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe_n,
   output logic      [WIDTH-1:0] data_rd,
   output logic      [WIDTH-1:0] dir_q
);
   logic [WIDTH-1:0] data_q;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         data_q <= WIDTH'(BPG_DATA_RST);
      else if (data_we)
         data_q <= wdata;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         dir_q <= WIDTH'(BPG_DIR_RST);
      else if (dir_we)
         dir_q <= wdata;
   end

   // Bus function owns the drivers while active; GPIO settings wait outside
   always_comb
   begin
      if (bus_use)
      begin
         pin_out  = bus_out;
         pin_oe_n = ~bus_drive;
      end
      else
      begin
         pin_out  = data_q;
         pin_oe_n = ~dir_q;
      end
   end

   assign data_rd = (dir_q & data_q) | (~dir_q & pin_in);
endmodule

/* hdl/bpg_regbank.sv */
// Register port decode and read-back for the bus port bank
`timescale 1ns/1ps
module bpg_regbank
   import bpg_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [2:0]  mode,
   input  wire logic [7:0]  hi_rd,
   input  wire logic [7:0]  lo_rd,
   input  wire logic [7:0]  hi_dir,
   input  wire logic [7:0]  lo_dir,
   output logic             hi_data_we,
   output logic             lo_data_we,
   output logic             hi_dir_we,
   output logic             lo_dir_we,
   output logic             ext_echo,
   output logic [7:0]       reg_rdata
);
   logic       ports_mapped;
   logic       rsv_mapped;
   logic       hit_port;
   logic       hit_rsv;
   logic [7:0] next_rdata;

   // Only the two single-chip modes keep the ports on chip; every expanded mode echoes
   assign ports_mapped = (mode == BPG_MODE_SS_SINGLE) || (mode == BPG_MODE_NS_SINGLE);
   assign rsv_mapped   = (mode != BPG_MODE_PERIPHERAL);
   assign hit_port     = ports_mapped && (reg_addr <= BPG_OFS_LO_DIR);
   assign hit_rsv      = rsv_mapped && (((reg_addr >= BPG_OFS_RSV_LO)
                         && (reg_addr <= BPG_OFS_RSV_HI)) || (reg_addr == BPG_OFS_RSV_F));

   // Writes take effect at any time while mapped
   assign hi_data_we = reg_wr && ports_mapped && (reg_addr == BPG_OFS_HI_DATA);
   assign lo_data_we = reg_wr && ports_mapped && (reg_addr == BPG_OFS_LO_DATA);
   assign hi_dir_we  = reg_wr && ports_mapped && (reg_addr == BPG_OFS_HI_DIR);
   assign lo_dir_we  = reg_wr && ports_mapped && (reg_addr == BPG_OFS_LO_DIR);
   // Unclaimed accesses are passed out to the external bus
   assign ext_echo   = (reg_wr || reg_rd) && !hit_port && !hit_rsv;

   always_comb
   begin
      next_rdata = 8'h00;
      if (!ports_mapped)
         next_rdata = 8'h00;
      else if (reg_addr == BPG_OFS_HI_DATA)
         next_rdata = hi_rd;
      else if (reg_addr == BPG_OFS_LO_DATA)
         next_rdata = lo_rd;
      else if (reg_addr == BPG_OFS_HI_DIR)
         next_rdata = hi_dir;
      else if (reg_addr == BPG_OFS_LO_DIR)
         next_rdata = lo_dir;
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= 8'h00;
   end
endmodule

/* testbench/bpg_pins_model.sv */
// Far-side model of one 8-bit port: the board wiring and an outside driver
`timescale 1ns/1ps
module bpg_pins_model
(
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pin_in
);
   // The block wins where it drives; the outside driver holds every other pin
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule

/* testbench/tb.sv */
// Self-checking bench for the bus port GPIO block
`timescale 1ns/1ps
module tb;
   import bpg_pkg::*;
   logic        sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ext_echo;
   logic        bus_use = 0, ext_data_phase = 0, ext_data_drive = 0, ext_wide = 0;
   logic [2:0]  mode = 3'h0;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, rd_exp, ldir;
   logic [7:0]  hi_pin_in, hi_pin_out, hi_pin_oe_n, lo_pin_in, lo_pin_out, lo_pin_oe_n;
   logic [15:0] ext_addr = 16'h0000, ext_wdata = 16'h0000;
   logic        rd_pend = 0, echo_exp = 0, unm;
   logic [3:0]  rsv [5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
   int          n_fail = 0, n_tests = 0, cycles = 0;

   bpg_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode(mode), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_echo(ext_echo), .bus_use(bus_use), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .ext_data_phase(ext_data_phase), .ext_data_drive(ext_data_drive), .ext_wide(ext_wide),
      .hi_pin_in(hi_pin_in), .hi_pin_out(hi_pin_out), .hi_pin_oe_n(hi_pin_oe_n),
      .lo_pin_in(lo_pin_in), .lo_pin_out(lo_pin_out), .lo_pin_oe_n(lo_pin_oe_n));
   bpg_pins_model hi_side (.pin_out(hi_pin_out), .pin_oe_n(hi_pin_oe_n), .ext_val(8'h5a),
      .pin_in(hi_pin_in));
   bpg_pins_model lo_side (.pin_out(lo_pin_out), .pin_oe_n(lo_pin_oe_n), .ext_val(8'hc3),
      .pin_in(lo_pin_in));

   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task test_done;
      $display("Checks made: %0d, mismatches: %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // One register port cycle; the strobes stay as set until the next call
   task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
   endtask

   // Read data stand only in the following cycle, so they are judged at its mid-point
   task rd(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, 1'b1, a, 8'h00);
      rd_exp = e;
      rd_pend = 1;
   endtask

   task pins(input logic [7:0] hoe, input logic [7:0] ho, input logic [7:0] loe,
             input logic [7:0] lo);
      @(negedge sys_clk);
      chk({hi_pin_oe_n, hi_pin_out, lo_pin_oe_n, lo_pin_out}, {hoe, ho, loe, lo});
      @(posedge sys_clk);
   endtask

   always @(negedge sys_clk)
   begin
      if (rd_pend)
      begin
         chk({24'h0, reg_rdata}, {24'h0, rd_exp});
         rd_pend = 0;
      end
      if (reg_wr | reg_rd)
         chk({31'h0, ext_echo}, {31'h0, echo_exp});
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_fail++;
         test_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      pins(8'hff, 8'h00, 8'hff, 8'h00);
      rd(4'h2, 8'h00);
      rd(4'h3, 8'h00);
      bus(1'b1, 1'b0, 4'h0, 8'ha5);
      bus(1'b1, 1'b0, 4'h1, 8'h3c);
      bus(1'b1, 1'b0, 4'h2, 8'hf0);
      rd(4'h2, 8'hf0);
      bus(1'b1, 1'b0, 4'h3, 8'h0f);
      rd(4'h0, 8'haa);
      rd(4'h1, 8'hcc);
      rd(4'h2, 8'hf0);
      rd(4'h3, 8'h0f);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      pins(8'h0f, 8'ha5, 8'hf0, 8'h3c);
      foreach (rsv[i])
      begin
         bus(1'b1, 1'b0, rsv[i], 8'hff);
         rd(rsv[i], 8'h00);
      end
      ldir = 8'h0f;
      for (int m = 0; m < 8; m++)
      begin
         unm = (m[1:0] != 2'b00);
         mode <= m[2:0];
         echo_exp = unm;
         bus(1'b1, 1'b0, 4'h3, 8'h40 + m[7:0]);
         if (!unm)
            ldir = 8'h40 + m[7:0];
         rd(4'h3, unm ? 8'h00 : ldir);
         echo_exp = (m == 2);
         rd(4'h4, 8'h00);
         echo_exp = 1;
         rd(4'h8, 8'h00);
      end
      mode <= 3'h0;
      echo_exp = 0;
      rd(4'h3, ldir);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      bus_use <= 1'b1;
      ext_addr <= 16'h1234;
      pins(8'h00, 8'h12, 8'h00, 8'h34);
      ext_data_phase <= 1'b1;
      ext_data_drive <= 1'b1;
      ext_wide <= 1'b1;
      ext_wdata <= 16'hbeef;
      pins(8'h00, 8'hbe, 8'h00, 8'hef);
      ext_wide <= 1'b0;
      @(negedge sys_clk);
      chk({8'h0, hi_pin_oe_n, hi_pin_out, lo_pin_oe_n}, {8'h0, 8'h00, 8'hef, 8'hff});
      @(posedge sys_clk);
      bus_use <= 1'b0;
      pins(8'h0f, 8'ha5, ~ldir, 8'h3c);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(4'h2, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      repeat (2) @(posedge sys_clk);
      test_done;
   end
endmodule
